// ===== hw/pmic_seq_pkg.sv
// Shared constants and types for the power sequencing and sleep control block.
package pmic_seq_pkg;

   // Clock and boot slot timing.
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SLOT_SHORT_NS = 500000;
   localparam int unsigned SLOT_LONG_NS  = 2000000;
   localparam int unsigned SLOT_SHORT_CYC_DFLT = (SLOT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SLOT_LONG_CYC_DFLT  = (SLOT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Slot numbers in which each resource comes up.
   localparam logic [3:0] SLOT_ZERO  = 4'h0;
   localparam logic [3:0] SLOT_PLL   = 4'h1;
   localparam logic [3:0] SLOT_CORE  = 4'h2;
   localparam logic [3:0] SLOT_IO    = 4'h3;
   localparam logic [3:0] SLOT_CLK   = 4'h5;
   localparam logic [3:0] SLOT_RESET = 4'h8;

   // APB register byte addresses.
   localparam logic [7:0] ADDR_DEV_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_DEV_CTRL2 = 8'h04;
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_MASK_ONE  = 8'h0C;
   localparam logic [7:0] ADDR_MASK_TWO  = 8'h10;
   localparam logic [7:0] ADDR_KEEP_ON   = 8'h14;
   localparam logic [7:0] ADDR_SET_OFF   = 8'h18;
   localparam logic [7:0] ADDR_EN_ASSIGN = 8'h1C;
   localparam logic [7:0] ADDR_OP_A      = 8'h20;
   localparam logic [7:0] ADDR_OP_B      = 8'h24;
   localparam logic [7:0] ADDR_SR_A      = 8'h28;
   localparam logic [7:0] ADDR_SR_B      = 8'h2C;
   localparam logic [7:0] ADDR_STATE     = 8'h30;

   // Control bit positions.
   localparam int CTL_CLK_GATE = 0;
   localparam int CTL_CLK_SRC  = 1;
   localparam int CTL_PIN_FUNC = 2;
   localparam int CTL_SLP_ALLOW = 3;
   localparam int CT2_SLOT_LEN = 0;
   localparam int CT2_IRQ_POL  = 1;
   localparam int CT2_SLP_POL  = 2;
   localparam int CT2_RESTORE  = 3;

   // Status flag positions; the sixth flag is masked by mask register two.
   localparam int FL_SUP_INS = 0;
   localparam int FL_PWR_HOLD = 1;
   localparam int FL_BUTTON  = 2;
   localparam int FL_HOT     = 3;
   localparam int FL_LOW_SUP = 4;
   localparam int FL_GPIO    = 5;

   // Resource positions in the enable, keep-on and set-off vectors.
   localparam int RS_CORE_A = 0;
   localparam int RS_CORE_B = 1;
   localparam int RS_IO     = 2;
   localparam int RS_PLL    = 3;
   localparam int RS_DIG2   = 4;

   // Synchronised input positions.
   localparam int IN_SLEEP = 0;
   localparam int IN_EN1   = 1;
   localparam int IN_EN2   = 2;
   localparam int IN_BTN   = 3;
   localparam int IN_SUP   = 4;
   localparam int IN_HOT   = 5;
   localparam int IN_LOW   = 6;
   localparam int IN_GPIO  = 7;

   // Reset values.
   localparam logic [3:0] DEV_CTRL_RST  = 4'h0;
   localparam logic [3:0] DEV_CTRL2_RST = 4'h1;
   localparam logic [4:0] MASK_ONE_RST  = 5'h01;
   localparam logic [6:0] BOOT_LEVEL    = 7'h00;

   typedef enum logic [2:0] {ST_NO_SUPPLY, ST_OFF, ST_SEQ, ST_ACTIVE, ST_SLEEP} pwr_state_e;

endpackage

// ===== hw/pmic_sequence_sleep_control.sv
// Boot sequencer, sleep control, voltage scaling and event flags with an APB register file.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Slot lasts 0.5 ms or 2 ms.
// - Resources enable in slots; reset after eight.
// - Interrupt output polarity follows polarity bit.
// - Mask clear means auto power-on at insertion.
// - Slow clock source select drives clock mux.
// - Pin-function bit turns serial pins into enables.
// - Sleep input polarity selectable, default active low.
// - Sleep honoured only when sleep allowed.
// - No sleep entry while interrupt pending.
// - Wake restores levels, or boot levels.
// - Enable-assigned converters ignore the sleep input.
// - Enable high gives roof, low floor.
// - Floor operation low power unless keep-on.
// - Sleep reduces transient response unless keep-on.
// - Sleep switches off set-off resources.
// - Supply insertion sets supply-inserted flag.
// - Off-to-active sets power-hold flag, releases reset.
// - Button press flags and wakes device.
// - Over-temperature input sets its flag.
// - Low input supply sets its flag.
// - Pin event wakes only from sleep.
// - Clock-gate bit gates timekeeper clock.
module pmic_sequence_sleep_control
#(
   parameter int unsigned SLOT_SHORT_CYC = pmic_seq_pkg::SLOT_SHORT_CYC_DFLT,
   parameter int unsigned SLOT_LONG_CYC  = pmic_seq_pkg::SLOT_LONG_CYC_DFLT
)
(
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Asynchronous pins and analogue monitors.
   input  wire logic        sleepPin,
   input  wire logic        enablePinOne,
   input  wire logic        enablePinTwo,
   input  wire logic        powerButton,
   input  wire logic        supplyPresent,
   input  wire logic        overTempIn,
   input  wire logic        lowSupplyIn,
   input  wire logic        gpioEvent,
   // Resource controls.
   output logic [4:0]       resourceOn,
   output logic [4:0]       resourceLowPower,
   output logic [6:0]       coreALevel,
   output logic [6:0]       coreBLevel,
   output logic             slowClockOutOn,
   output logic             powerOnResetOutN,
   output logic             irqOut,
   // Static mode outputs.
   output logic             slowClockSourceRc,
   output logic             timekeeperClockGate,
   output logic             pinFunctionSelect
);
   import pmic_seq_pkg::*;

   typedef struct packed {
      pwr_state_e  state;
      logic [15:0] slotCnt;
      logic [3:0]  slot;
      logic [7:0]  sy1;
      logic [7:0]  sy2;
      logic [7:0]  prev;
      logic [3:0]  devCtrl;
      logic [3:0]  devCtrl2;
      logic [5:0]  status;
      logic [4:0]  maskOne;
      logic        maskTwo;
      logic [4:0]  keepOn;
      logic [4:0]  setOff;
      logic [1:0]  enAssign;
      logic [6:0]  opA;
      logic [6:0]  opB;
      logic [6:0]  srA;
      logic [6:0]  srB;
      logic [4:0]  resOn;
      logic [4:0]  lowPwr;
      logic [6:0]  lvlA;
      logic [6:0]  lvlB;
      logic        clkOn;
      logic        porN;
      logic        irq;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } ctl_s;

   ctl_s q_ff;
   ctl_s nxt_q;

   // Voltage of a converter: roof from the operating level, floor when its pin is low.
   function automatic logic [6:0] coreLevel(input logic onPin, input logic pinHigh,
                                            input logic [6:0] roof, input logic [6:0] floorLvl);
      coreLevel = (onPin && !pinHigh) ? floorLvl : roof;
   endfunction

   // A resource is up once the sequence has reached its slot.
   function automatic logic slotReached(input logic [3:0] cur, input logic [3:0] mine);
      slotReached = cur >= mine;
   endfunction

   // Address decode shared by the write decode and the error answer.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= ADDR_STATE) && (a[1:0] == 2'h0);
   endfunction

   logic [7:0]  rise;
   logic [5:0]  setFlags;
   logic [5:0]  clrFlags;
   logic [5:0]  pending;
   logic        irqPending;
   logic        sleepReq;
   logic        wrEn;
   logic        setup;
   logic [15:0] slotLen;
   logic        inSleep;
   logic        pinOne;
   logic        pinTwo;
   logic        ctlA;
   logic        ctlB;
   logic        wake;
   logic [4:0]  seqOn;
   logic [4:0]  slpFree;

   always_comb
   begin
      nxt_q = q_ff;
      // Second stage only reads the first; all logic reads the second stage.
      nxt_q.sy1 = {gpioEvent, lowSupplyIn, overTempIn, supplyPresent,
                   powerButton, enablePinTwo, enablePinOne, sleepPin};
      nxt_q.sy2 = q_ff.sy1;
      nxt_q.prev = q_ff.sy2;
      rise = q_ff.sy2 & ~q_ff.prev;

      setup = psel && !penable;
      wrEn = psel && penable && q_ff.ready && pwrite;
      clrFlags = '0;
      setFlags = '0;

      // Register writes take effect at the completing access edge.
      if (wrEn && mapped(paddr))
      begin
         case (paddr)
            ADDR_DEV_CTRL:  nxt_q.devCtrl = pwdata[3:0];
            ADDR_DEV_CTRL2: nxt_q.devCtrl2 = pwdata[3:0];
            ADDR_STATUS:    clrFlags = pwdata[5:0];
            ADDR_MASK_ONE:  nxt_q.maskOne = pwdata[4:0];
            ADDR_MASK_TWO:  nxt_q.maskTwo = pwdata[0];
            ADDR_KEEP_ON:   nxt_q.keepOn = pwdata[4:0];
            ADDR_SET_OFF:   nxt_q.setOff = pwdata[4:0];
            ADDR_EN_ASSIGN: nxt_q.enAssign = pwdata[1:0];
            ADDR_OP_A:      nxt_q.opA = pwdata[6:0];
            ADDR_OP_B:      nxt_q.opB = pwdata[6:0];
            ADDR_SR_A:      nxt_q.srA = pwdata[6:0];
            ADDR_SR_B:      nxt_q.srB = pwdata[6:0];
            default:        nxt_q.slverr = q_ff.slverr;
         endcase
      end

      // The two interrupt masks together select wake and interrupt sources.
      pending = q_ff.status & ~{q_ff.maskTwo, q_ff.maskOne};
      irqPending = |pending;

      // Sleep level as seen after polarity.
      sleepReq = q_ff.devCtrl2[CT2_SLP_POL] ? q_ff.sy2[IN_SLEEP] : !q_ff.sy2[IN_SLEEP];

      slotLen = q_ff.devCtrl2[CT2_SLOT_LEN] ? 16'(SLOT_LONG_CYC) : 16'(SLOT_SHORT_CYC);

      // Pin events always raise their flags.
      setFlags[FL_BUTTON] = rise[IN_BTN];
      setFlags[FL_HOT] = rise[IN_HOT];
      setFlags[FL_LOW_SUP] = rise[IN_LOW];
      setFlags[FL_GPIO] = rise[IN_GPIO];

      wake = 1'b0;
      case (q_ff.state)
         ST_NO_SUPPLY:
         begin
            if (q_ff.sy2[IN_SUP])
            begin
               setFlags[FL_SUP_INS] = 1'b1;
               nxt_q.slot = SLOT_ZERO;
               nxt_q.slotCnt = '0;
               // With the mask clear the device powers up with no start-up reason.
               nxt_q.state = q_ff.maskOne[FL_SUP_INS] ? ST_OFF : ST_SEQ;
            end
         end
         ST_OFF:
         begin
            // A pin event is no start-up reason from off; the button is.
            if (rise[IN_BTN])
            begin
               nxt_q.slot = SLOT_ZERO;
               nxt_q.slotCnt = '0;
               nxt_q.state = ST_SEQ;
            end
         end
         ST_SEQ:
         begin
            if (q_ff.slotCnt >= slotLen - 16'h0001)
            begin
               nxt_q.slotCnt = '0;
               nxt_q.slot = q_ff.slot + 4'h1;
               if (q_ff.slot + 4'h1 == SLOT_RESET)
               begin
                  nxt_q.state = ST_ACTIVE;
                  setFlags[FL_PWR_HOLD] = 1'b1;
               end
            end
            else
            begin
               nxt_q.slotCnt = q_ff.slotCnt + 16'h0001;
            end
         end
         ST_ACTIVE:
         begin
            // Pending interrupts block sleep so no event is slept through.
            if (sleepReq && q_ff.devCtrl[CTL_SLP_ALLOW] && !irqPending)
            begin
               nxt_q.state = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            // Any unmasked event, including a pin event, wakes from sleep.
            if (!sleepReq || irqPending || rise[IN_BTN])
            begin
               wake = 1'b1;
               nxt_q.state = ST_ACTIVE;
            end
         end
         default:
         begin
            nxt_q.state = ST_NO_SUPPLY;
         end
      endcase

      // Losing the input supply drops everything regardless of state.
      if (!q_ff.sy2[IN_SUP])
      begin
         nxt_q.state = ST_NO_SUPPLY;
         nxt_q.slot = SLOT_ZERO;
         nxt_q.slotCnt = '0;
      end

      // A new event wins over a software clear in the same cycle.
      nxt_q.status = (q_ff.status & ~clrFlags) | setFlags;

      // Pre-sleep levels stay in place unless boot levels are requested.
      if (wake && q_ff.devCtrl2[CT2_RESTORE])
      begin
         nxt_q.opA = BOOT_LEVEL;
         nxt_q.opB = BOOT_LEVEL;
      end

      // Enable pins only exist when the serial pins are switched over.
      pinOne = q_ff.devCtrl[CTL_PIN_FUNC] ? q_ff.sy2[IN_EN1] : 1'b1;
      pinTwo = q_ff.devCtrl[CTL_PIN_FUNC] ? q_ff.sy2[IN_EN2] : 1'b1;
      ctlA = q_ff.enAssign[RS_CORE_A];
      ctlB = q_ff.enAssign[RS_CORE_B];

      inSleep = q_ff.state == ST_SLEEP;
      // Assigned converters are released from sleep control entirely.
      slpFree = {3'h0, ctlB, ctlA};

      seqOn[RS_PLL] = slotReached(q_ff.slot, SLOT_PLL);
      seqOn[RS_CORE_A] = slotReached(q_ff.slot, SLOT_CORE);
      seqOn[RS_CORE_B] = slotReached(q_ff.slot, SLOT_CORE);
      seqOn[RS_DIG2] = slotReached(q_ff.slot, SLOT_CORE);
      seqOn[RS_IO] = slotReached(q_ff.slot, SLOT_IO);

      if (q_ff.state == ST_SEQ || q_ff.state == ST_ACTIVE || q_ff.state == ST_SLEEP)
      begin
         // Set-off resources not assigned to an enable pin drop in sleep, the rest stay up.
         nxt_q.resOn = seqOn & ~({5{inSleep}} & q_ff.setOff & ~slpFree);
         // Default sleep behaviour is reduced transient response.
         nxt_q.lowPwr = {5{inSleep}} & ~q_ff.keepOn & ~slpFree;
         nxt_q.clkOn = slotReached(q_ff.slot, SLOT_CLK);
         nxt_q.porN = q_ff.slot == SLOT_RESET;
      end
      else
      begin
         nxt_q.resOn = '0;
         nxt_q.lowPwr = '0;
         nxt_q.clkOn = 1'b0;
         nxt_q.porN = 1'b0;
      end

      // Floor operation runs pulse-frequency mode unless kept on.
      if (ctlA)
      begin
         nxt_q.lowPwr[RS_CORE_A] = !pinOne && !q_ff.keepOn[RS_CORE_A];
      end
      if (ctlB)
      begin
         nxt_q.lowPwr[RS_CORE_B] = !pinTwo && !q_ff.keepOn[RS_CORE_B];
      end
      nxt_q.lvlA = coreLevel(ctlA, pinOne, q_ff.opA, q_ff.srA);
      nxt_q.lvlB = coreLevel(ctlB, pinTwo, q_ff.opB, q_ff.srB);

      // Interrupt stays asserted until every unmasked flag is cleared.
      nxt_q.irq = q_ff.devCtrl2[CT2_IRQ_POL] ? irqPending : !irqPending;

      // APB answers in the first cycle of the access phase.
      nxt_q.ready = setup;
      nxt_q.slverr = setup && !mapped(paddr);
      if (setup)
      begin
         case (paddr)
            ADDR_DEV_CTRL:  nxt_q.rdata = {28'h0000000, q_ff.devCtrl};
            ADDR_DEV_CTRL2: nxt_q.rdata = {28'h0000000, q_ff.devCtrl2};
            ADDR_STATUS:    nxt_q.rdata = {26'h0000000, q_ff.status};
            ADDR_MASK_ONE:  nxt_q.rdata = {27'h0000000, q_ff.maskOne};
            ADDR_MASK_TWO:  nxt_q.rdata = {31'h00000000, q_ff.maskTwo};
            ADDR_KEEP_ON:   nxt_q.rdata = {27'h0000000, q_ff.keepOn};
            ADDR_SET_OFF:   nxt_q.rdata = {27'h0000000, q_ff.setOff};
            ADDR_EN_ASSIGN: nxt_q.rdata = {30'h00000000, q_ff.enAssign};
            ADDR_OP_A:      nxt_q.rdata = {25'h0000000, q_ff.opA};
            ADDR_OP_B:      nxt_q.rdata = {25'h0000000, q_ff.opB};
            ADDR_SR_A:      nxt_q.rdata = {25'h0000000, q_ff.srA};
            ADDR_SR_B:      nxt_q.rdata = {25'h0000000, q_ff.srB};
            ADDR_STATE:     nxt_q.rdata = {25'h0000000, q_ff.state, q_ff.slot};
            default:        nxt_q.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q_ff <= '0;
         q_ff.state <= ST_NO_SUPPLY;
         q_ff.devCtrl <= DEV_CTRL_RST;
         q_ff.devCtrl2 <= DEV_CTRL2_RST;
         q_ff.maskOne <= MASK_ONE_RST;
         q_ff.maskTwo <= 1'b1;
         q_ff.opA <= BOOT_LEVEL;
         q_ff.opB <= BOOT_LEVEL;
         q_ff.srA <= BOOT_LEVEL;
         q_ff.srB <= BOOT_LEVEL;
         q_ff.irq <= 1'b1;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   assign prdata = q_ff.rdata;
   assign pready = q_ff.ready;
   assign pslverr = q_ff.slverr;
   assign resourceOn = q_ff.resOn;
   assign resourceLowPower = q_ff.lowPwr;
   assign coreALevel = q_ff.lvlA;
   assign coreBLevel = q_ff.lvlB;
   assign slowClockOutOn = q_ff.clkOn;
   assign powerOnResetOutN = q_ff.porN;
   assign irqOut = q_ff.irq;
   assign slowClockSourceRc = q_ff.devCtrl[CTL_CLK_SRC];
   assign timekeeperClockGate = q_ff.devCtrl[CTL_CLK_GATE];
   assign pinFunctionSelect = q_ff.devCtrl[CTL_PIN_FUNC];

endmodule

`default_nettype wire

// ===== test/pmic_seq_asserts.sv
// Port-level checker for the sequencing and sleep block.
`timescale 1ns/1ps
`default_nettype none
module pmic_seq_asserts
import pmic_seq_pkg::*;
#(
   parameter int unsigned SLOT_SHORT_CYC = 4,
   parameter int unsigned SLOT_LONG_CYC  = 8
)
(
   // Clock, reset and bus.
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Watched outputs.
   input wire logic [4:0]  resourceOn,
   input wire logic        slowClockOutOn,
   input wire logic        powerOnResetOutN,
   input wire logic        slowClockSourceRc,
   input wire logic        timekeeperClockGate,
   input wire logic        pinFunctionSelect
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   logic [15:0] gap_ff;
   logic [15:0] nxt_gap;

   // Slot length is judged by the gap between the first two boot steps.
   always_comb
   begin
      nxt_gap = (resourceOn[RS_PLL] && !resourceOn[RS_CORE_A]) ? gap_ff + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         gap_ff <= 16'h0000;
      else
         gap_ff <= nxt_gap;
   end

   property p_apbAnswer;
      psel && !penable |=> pready;
   endproperty
   a_apbAnswer: assert property (p_apbAnswer) else $error("No answer after setup.");

   property p_readyAccess;
      pready |-> psel && penable && $past(psel && !penable);
   endproperty
   a_readyAccess: assert property (p_readyAccess) else $error("Ready outside access.");

   property p_slvErr;
      pready |-> pslverr == (paddr > ADDR_STATE || paddr[1:0] != 2'h0);
   endproperty
   a_slvErr: assert property (p_slvErr) else $error("Slave error wrong.");

   property p_ctrlBits;
      psel && penable && pready && pwrite && paddr == ADDR_DEV_CTRL
      |=> slowClockSourceRc == $past(pwdata[CTL_CLK_SRC]) && timekeeperClockGate == $past(pwdata[CTL_CLK_GATE])
          && pinFunctionSelect == $past(pwdata[CTL_PIN_FUNC]);
   endproperty
   a_ctrlBits: assert property (p_ctrlBits) else $error("Control outputs wrong.");

   property p_slotGap;
      $rose(resourceOn[RS_CORE_A]) && !powerOnResetOutN |-> gap_ff == SLOT_SHORT_CYC || gap_ff == SLOT_LONG_CYC;
   endproperty
   a_slotGap: assert property (p_slotGap) else $error("Slot length wrong.");

   property p_coreSlot;
      $rose(resourceOn[RS_CORE_A]) && !powerOnResetOutN
      |-> resourceOn[RS_PLL] && resourceOn[RS_CORE_B] && resourceOn[RS_DIG2] && !resourceOn[RS_IO];
   endproperty
   a_coreSlot: assert property (p_coreSlot) else $error("Core slot order wrong.");

   property p_clkSlot;
      $rose(slowClockOutOn) |-> resourceOn[RS_IO] && !powerOnResetOutN;
   endproperty
   a_clkSlot: assert property (p_clkSlot) else $error("Clock slot order wrong.");

   property p_resetLast;
      $rose(powerOnResetOutN) |-> slowClockOutOn && resourceOn == 5'h1F;
   endproperty
   a_resetLast: assert property (p_resetLast) else $error("Reset released early.");

   c_boot: cover property ($rose(powerOnResetOutN));
   c_err: cover property (pready && pslverr);
   c_sleep: cover property ($fell(resourceOn[RS_CORE_A]) && powerOnResetOutN);
endmodule

bind pmic_sequence_sleep_control pmic_seq_asserts #(
   .SLOT_SHORT_CYC(SLOT_SHORT_CYC),
   .SLOT_LONG_CYC (SLOT_LONG_CYC)
) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .resourceOn(resourceOn),
   .slowClockOutOn(slowClockOutOn), .powerOnResetOutN(powerOnResetOutN),
   .slowClockSourceRc(slowClockSourceRc), .timekeeperClockGate(timekeeperClockGate),
   .pinFunctionSelect(pinFunctionSelect)
);
`default_nettype wire

// ===== test/pmic_proc_model.sv
// Processor-side model driving sleep, enable, button and monitor pins.
`timescale 1ns/1ps
`default_nettype none
module pmic_proc_model
(
   // Clock and requested levels.
   input  wire logic       mclk,
   input  wire logic [7:0] want,
   // Pin levels toward the device.
   output wire logic [7:0] pins
);
   logic [7:0] pins_ff = 8'h01;

   // Pins move only just after an edge, like a processor output register.
   always @(posedge mclk)
   begin
      pins_ff <= want;
   end

   assign pins = pins_ff;
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the sequencing and sleep block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pmic_seq_pkg::*;
   localparam int SL = 8;
   localparam int SS = 4;
   logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, want, pins;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  resourceOn, resourceLowPower;
   logic [6:0]  coreALevel, coreBLevel;
   logic        slowClockOutOn, powerOnResetOutN, irqOut, clkRc, clkGate, pinFunc;
   int          num_errors, num_checks, cycles;

   pmic_sequence_sleep_control #(.SLOT_SHORT_CYC(SS), .SLOT_LONG_CYC(SL)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepPin(pins[IN_SLEEP]),
      .enablePinOne(pins[IN_EN1]), .enablePinTwo(pins[IN_EN2]), .powerButton(pins[IN_BTN]),
      .supplyPresent(pins[IN_SUP]), .overTempIn(pins[IN_HOT]), .lowSupplyIn(pins[IN_LOW]),
      .gpioEvent(pins[IN_GPIO]), .resourceOn(resourceOn), .resourceLowPower(resourceLowPower),
      .coreALevel(coreALevel), .coreBLevel(coreBLevel), .slowClockOutOn(slowClockOutOn),
      .powerOnResetOutN(powerOnResetOutN), .irqOut(irqOut), .slowClockSourceRc(clkRc),
      .timekeeperClockGate(clkGate), .pinFunctionSelect(pinFunc));
   pmic_proc_model u_proc (.mclk(mclk), .want(want), .pins(pins));

   task automatic finish_test;
      $display("Checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   // Holds the request until pready is sampled high, then releases it.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer.
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge mclk);
   endtask

   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask

   task automatic pin(input int b, input logic v, input int n);
      @(posedge mclk);
      want[b] <= v;
      repeat (n) @(posedge mclk);
   endtask

   // Counts cycles from the first boot step to reset release.
   task automatic boot(input int e);
      int n;
      n = 0;
      while (resourceOn[RS_PLL] !== 1'b1 && n < 500)
      begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      while (powerOnResetOutN !== 1'b1 && n < 500)
      begin
         @(posedge mclk);
         n++;
      end
      chk("boot", e, n);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, want} = {1'b1, 3'h0, 8'h00, 32'h0, 8'h01};
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      chk("irq", 1, irqOut);
      rdc("ctrl2", ADDR_DEV_CTRL2, 32'h1);
      rdc("mask1", ADDR_MASK_ONE, 32'h1);
      apb(1'b0, 8'h34, 32'h0);
      chk("slverr", 1, err);
      $display("Test reset done");
      pin(IN_SUP, 1'b1, 8);
      chk("on", 0, resourceOn);
      pin(IN_BTN, 1'b1, 0);
      boot(7 * SL);
      pin(IN_BTN, 1'b0, 2);
      rdc("status", ADDR_STATUS, 32'h07);
      chk("irq", 0, irqOut);
      pin(IN_SUP, 1'b0, 8);
      wr(ADDR_DEV_CTRL2, 32'h0);
      wr(ADDR_MASK_ONE, 32'h0);
      pin(IN_SUP, 1'b1, 0);
      boot(7 * SS);
      wr(ADDR_STATUS, 32'h3F);
      chk("irq", 1, irqOut);
      wr(ADDR_DEV_CTRL2, 32'h2);
      chk("irq", 0, irqOut);
      pin(IN_HOT, 1'b1, 8);
      chk("irq", 1, irqOut);
      rdc("status", ADDR_STATUS, 32'h08);
      pin(IN_HOT, 1'b0, 1);
      wr(ADDR_DEV_CTRL2, 32'h0);
      wr(ADDR_STATUS, 32'h3F);
      $display("Test boot and irq done");
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_DEV_CTRL, i);
         chk("ctrl", i, {pinFunc, clkRc, clkGate});
      end
      wr(ADDR_SET_OFF, 32'h3);
      wr(ADDR_KEEP_ON, 32'h4);
      wr(ADDR_OP_A, 32'h55);
      wr(ADDR_DEV_CTRL, 32'h0);
      pin(IN_SLEEP, 1'b0, 8);
      chk("on", 5'h1F, resourceOn);
      pin(IN_LOW, 1'b1, 8);
      pin(IN_LOW, 1'b0, 1);
      wr(ADDR_DEV_CTRL, 32'h8);
      chk("on", 5'h1F, resourceOn);
      rdc("status", ADDR_STATUS, 32'h10);
      wr(ADDR_STATUS, 32'h3F);
      // Sleep entry follows the clear by one edge and the outputs by one more.
      @(posedge mclk);
      chk("on", 5'h1C, resourceOn);
      chk("lp", 5'h18, resourceLowPower & 5'h1C);
      wr(ADDR_MASK_TWO, 32'h0);
      pin(IN_GPIO, 1'b1, 8);
      pin(IN_GPIO, 1'b0, 1);
      chk("on", 5'h1F, resourceOn);
      chk("lvl", 7'h55, coreALevel);
      wr(ADDR_STATUS, 32'h3F);
      wr(ADDR_DEV_CTRL2, 32'h8);
      pin(IN_SLEEP, 1'b1, 8);
      chk("lvl", BOOT_LEVEL, coreALevel);
      $display("Test sleep done");
      wr(ADDR_DEV_CTRL2, 32'h0);
      wr(ADDR_DEV_CTRL, 32'hC);
      wr(ADDR_EN_ASSIGN, 32'h3);
      wr(ADDR_OP_A, 32'h55);
      wr(ADDR_SR_A, 32'h22);
      wr(ADDR_SR_B, 32'h33);
      pin(IN_EN1, 1'b1, 8);
      chk("lvl", 7'h55, coreALevel);
      chk("lvlB", 7'h33, coreBLevel);
      pin(IN_EN1, 1'b0, 8);
      chk("lvl", 7'h22, coreALevel);
      chk("lp", 1, resourceLowPower[RS_CORE_A]);
      wr(ADDR_KEEP_ON, 32'h5);
      chk("lp", 0, resourceLowPower[RS_CORE_A]);
      pin(IN_SLEEP, 1'b0, 8);
      chk("on", 5'h1F, resourceOn);
      rdc("state", ADDR_STATE, 32'h48);
      $display("Test enable pins done");
      finish_test();
   end
endmodule
`default_nettype wire
